// File: shared/ebrt_map.svh
`ifndef EBRT_MAP_SVH
`define EBRT_MAP_SVH

// ============================================================
// Register offsets and fields.
`define EBRT_ADDR_W        8
`define EBRT_OFF_MODE      8'h00
`define EBRT_OFF_COUNT     8'h04
`define EBRT_OFF_IRQ_REQ   8'h08
`define EBRT_OFF_IRQ_EN    8'h0C
`define EBRT_OFF_EDGE      8'h10
`define EBRT_WORD_MASK     8'hFC
`define EBRT_MODE_RSVD     4'hF

// ============================================================
// Reset values and codes.
`define EBRT_COUNT_RST     8'h00
`define EBRT_RELOAD_RST    8'h00
`define EBRT_SRC_RST       3'h0
`define EBRT_AUTO_RST      1'h0
`define EBRT_EDGE_RST      1'h0
`define EBRT_SRC_EVENT     3'h7
`define EBRT_COUNT_MAX     8'hFF
`define EBRT_RESP_OKAY     2'h0
`define EBRT_RESP_SLVERR   2'h2

`endif

// File: shared/ebrt_pkg.sv
package ebrt_pkg;

	// ============================================================
	// Core state of the timer and its bus slave.
	typedef struct packed {
		logic        autoReload;
		logic [2:0]  srcSel;
		logic [7:0]  count;
		logic [7:0]  reload;
		logic        ovfFlag;
		logic        ovfEnable;
		logic        edgeRising;
		logic        cpuIrq;
		logic        awHeld;
		logic [7:0]  awAddr;
		logic        wHeld;
		logic [7:0]  wData;
		logic        wStrb0;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ebrt_core_t;

	// ============================================================
	// State of the count tick selector.
	typedef struct packed {
		logic pinPrev;
		logic tick;
	} ebrt_tick_t;

endpackage

// File: hw/ebrt_count_tick.sv
`timescale 1ns/1ps
`include "ebrt_map.svh"

module ebrt_count_tick (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst,
	// Count sources.
	input  wire logic [6:0] prescTick,
	input  wire logic       eventInputPin,
	// Selection.
	input  wire logic [2:0] srcSel,
	input  wire logic       edgeRising,
	// Result.
	output logic            countTick
);

	ebrt_pkg::ebrt_tick_t state_ff;
	ebrt_pkg::ebrt_tick_t nxt_state;
	logic                 pinEdge;

	// ============================================================
	// Source selection.
	// The pin edge is taken from one stored sample, so a pin held high through reset reads as a rising edge once.
	assign pinEdge = edgeRising ? (eventInputPin & ~state_ff.pinPrev) : (~eventInputPin & state_ff.pinPrev);

	always_comb begin
		nxt_state         = state_ff;
		nxt_state.pinPrev = eventInputPin;
		if (srcSel == `EBRT_SRC_EVENT) begin
			nxt_state.tick = pinEdge;
		end else begin
			nxt_state.tick = prescTick[srcSel];
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign countTick = state_ff.tick;

	// ============================================================
	// Checks.
	a_event_edge: assert property (@(posedge clock) disable iff (rst)
		(srcSel == `EBRT_SRC_EVENT && $stable(srcSel) && edgeRising && $rose(eventInputPin)) |=> countTick)
		else $error("Rising pin edge did not make a count tick.");
	a_tap_pick: assert property (@(posedge clock) disable iff (rst)
		(srcSel != `EBRT_SRC_EVENT) |=> (countTick == $past(prescTick[srcSel])))
		else $error("Count tick does not follow the selected prescaler tap.");

endmodule

// File: hw/ebrt_timer.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ebrt_map.svh"

module ebrt_timer (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst,
	// AXI4-Lite write address and data.
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response.
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read.
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Count sources.
	input  wire logic [6:0]  prescTick,
	input  wire logic        eventInputPin,
	// Interrupt request to the CPU.
	output logic             cpuIrq
);

	ebrt_pkg::ebrt_core_t state_ff;
	ebrt_pkg::ebrt_core_t nxt_state;
	logic                 countTick;
	logic                 doWrite;
	logic                 doRead;
	logic                 overflow;
	logic [7:0]           wAddrWord;
	logic [7:0]           rAddrWord;

	// ============================================================
	// Count source.
	ebrt_count_tick i_ebrt_count_tick (
		.clock         (clock),
		.rst           (rst),
		.prescTick     (prescTick),
		.eventInputPin (eventInputPin),
		.srcSel        (state_ff.srcSel),
		.edgeRising    (state_ff.edgeRising),
		.countTick     (countTick)
	);

	assign doWrite   = state_ff.awHeld & state_ff.wHeld & ~state_ff.bvalid;
	assign doRead    = arvalid & state_ff.arready;
	assign wAddrWord = state_ff.awAddr & `EBRT_WORD_MASK;
	assign rAddrWord = araddr & `EBRT_WORD_MASK;
	// A tick that meets a counter write is dropped, so it must not raise the flag either.
	assign overflow  = countTick & (state_ff.count == `EBRT_COUNT_MAX)
		& ~(doWrite & (wAddrWord == `EBRT_OFF_COUNT) & state_ff.wStrb0);

	// ============================================================
	// Next state.
	always_comb begin
		nxt_state = state_ff;

		// Counting. A reload write in the same cycle as a tick wins and the tick is dropped.
		if (countTick) begin
			if (state_ff.count == `EBRT_COUNT_MAX) begin
				nxt_state.count = state_ff.autoReload ? state_ff.reload : `EBRT_COUNT_RST;
			end else begin
				nxt_state.count = state_ff.count + 8'h01;
			end
		end

		// Write address and data are taken in either order.
		if (awvalid && state_ff.awready) begin
			nxt_state.awHeld = 1'b1;
			nxt_state.awAddr = awaddr;
		end
		if (wvalid && state_ff.wready) begin
			nxt_state.wHeld  = 1'b1;
			nxt_state.wData  = wdata[7:0];
			nxt_state.wStrb0 = wstrb[0];
		end

		nxt_state.bresp = state_ff.bresp;
		if (doWrite) begin
			nxt_state.awHeld = 1'b0;
			nxt_state.wHeld  = 1'b0;
			nxt_state.bvalid = 1'b1;
			nxt_state.bresp  = `EBRT_RESP_OKAY;
			case (wAddrWord)
				`EBRT_OFF_MODE: begin
					if (state_ff.wStrb0) begin
						nxt_state.autoReload = state_ff.wData[7];
						nxt_state.srcSel     = state_ff.wData[2:0];
					end
				end
				`EBRT_OFF_COUNT: begin
					if (state_ff.wStrb0) begin
						nxt_state.reload = state_ff.wData;
						nxt_state.count  = state_ff.wData;
					end
				end
				`EBRT_OFF_IRQ_REQ: begin
					if (state_ff.wStrb0 && state_ff.wData[0]) begin
						nxt_state.ovfFlag = 1'b0;
					end
				end
				`EBRT_OFF_IRQ_EN: begin
					if (state_ff.wStrb0) begin
						nxt_state.ovfEnable = state_ff.wData[0];
					end
				end
				`EBRT_OFF_EDGE: begin
					if (state_ff.wStrb0) begin
						nxt_state.edgeRising = state_ff.wData[0];
					end
				end
				default: begin
					nxt_state.bresp = `EBRT_RESP_SLVERR;
				end
			endcase
		end else if (state_ff.bvalid && bready) begin
			nxt_state.bvalid = 1'b0;
		end

		// Overflow comes after the clear so that a set in the clearing cycle is kept.
		if (overflow) begin
			nxt_state.ovfFlag = 1'b1;
		end
		nxt_state.cpuIrq = nxt_state.ovfFlag & nxt_state.ovfEnable;

		// Reads never touch the counter, so counting carries on undisturbed.
		if (doRead) begin
			nxt_state.rvalid = 1'b1;
			nxt_state.rresp  = `EBRT_RESP_OKAY;
			case (rAddrWord)
				`EBRT_OFF_MODE: begin
					nxt_state.rdata = {24'h000000, state_ff.autoReload, `EBRT_MODE_RSVD, state_ff.srcSel};
				end
				`EBRT_OFF_COUNT: begin
					nxt_state.rdata = {24'h000000, state_ff.count};
				end
				`EBRT_OFF_IRQ_REQ: begin
					nxt_state.rdata = {31'h00000000, state_ff.ovfFlag};
				end
				`EBRT_OFF_IRQ_EN: begin
					nxt_state.rdata = {31'h00000000, state_ff.ovfEnable};
				end
				`EBRT_OFF_EDGE: begin
					nxt_state.rdata = {31'h00000000, state_ff.edgeRising};
				end
				default: begin
					nxt_state.rdata = 32'h00000000;
					nxt_state.rresp = `EBRT_RESP_SLVERR;
				end
			endcase
		end else if (state_ff.rvalid && rready) begin
			nxt_state.rvalid = 1'b0;
		end

		// One write and one read at a time: readies drop while an answer is pending.
		nxt_state.awready = ~nxt_state.awHeld & ~nxt_state.bvalid;
		nxt_state.wready  = ~nxt_state.wHeld & ~nxt_state.bvalid;
		nxt_state.arready = ~nxt_state.rvalid;
	end

	// ============================================================
	// State register.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff            <= '0;
			state_ff.autoReload <= `EBRT_AUTO_RST;
			state_ff.srcSel     <= `EBRT_SRC_RST;
			state_ff.count      <= `EBRT_COUNT_RST;
			state_ff.reload     <= `EBRT_RELOAD_RST;
			state_ff.edgeRising <= `EBRT_EDGE_RST;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign awready = state_ff.awready;
	assign wready  = state_ff.wready;
	assign bvalid  = state_ff.bvalid;
	assign bresp   = state_ff.bresp;
	assign arready = state_ff.arready;
	assign rvalid  = state_ff.rvalid;
	assign rdata   = state_ff.rdata;
	assign rresp   = state_ff.rresp;
	assign cpuIrq  = state_ff.cpuIrq;

	// ============================================================
	// Checks.
	sequence seq_overflow;
		overflow && !(doWrite && wAddrWord == `EBRT_OFF_COUNT);
	endsequence

	sequence seq_count_write;
		doWrite && wAddrWord == `EBRT_OFF_COUNT && state_ff.wStrb0;
	endsequence

	a_wrap_zero: assert property (@(posedge clock) disable iff (rst)
		(seq_overflow and !state_ff.autoReload) |=> (state_ff.count == `EBRT_COUNT_RST))
		else $error("Interval overflow did not wrap to zero.");
	a_auto_reload: assert property (@(posedge clock) disable iff (rst)
		(seq_overflow and state_ff.autoReload) |=> (state_ff.count == $past(state_ff.reload)))
		else $error("Auto-reload overflow did not load the reload value.");
	a_flag_set: assert property (@(posedge clock) disable iff (rst)
		overflow |=> state_ff.ovfFlag ##1 (state_ff.ovfFlag || $past(doWrite)))
		else $error("Overflow did not set the request flag.");
	a_irq_gate: assert property (@(posedge clock) disable iff (rst)
		cpuIrq |-> (state_ff.ovfEnable && state_ff.ovfFlag))
		else $error("Interrupt raised without enable and flag.");
	a_reload_load: assert property (@(posedge clock) disable iff (rst)
		seq_count_write |=> (state_ff.count == $past(state_ff.wData) && state_ff.reload == state_ff.count))
		else $error("Reload write did not load counter and reload.");
	a_count_hold: assert property (@(posedge clock) disable iff (rst)
		(!countTick && !doWrite) |=> $stable(state_ff.count))
		else $error("Counter moved without a tick or write.");
	a_count_step: assert property (@(posedge clock) disable iff (rst)
		(countTick && !doWrite && state_ff.count != `EBRT_COUNT_MAX) |=> (state_ff.count == $past(state_ff.count) + 8'h01))
		else $error("Counter did not step by one on a tick.");
	a_count_read: assert property (@(posedge clock) disable iff (rst)
		(doRead && rAddrWord == `EBRT_OFF_COUNT) |=> (rvalid && rdata[7:0] == $past(state_ff.count)))
		else $error("Counter read returned the wrong value.");
	a_mode_rsvd: assert property (@(posedge clock) disable iff (rst)
		(doRead && rAddrWord == `EBRT_OFF_MODE) |=> (rdata[6:3] == `EBRT_MODE_RSVD && rresp == `EBRT_RESP_OKAY))
		else $error("Reserved mode bits did not read as ones.");

endmodule

// File: verification/ebrt_tap_model.sv
`timescale 1ns/1ps

module ebrt_tap_model (
	// Clock and reset.
	input  wire logic       clock,
	input  wire logic       rst,
	// Bench control.
	input  wire logic [2:0] tapSel,
	input  wire logic       fire,
	// Prescaler taps.
	output logic [6:0]      prescTick
);
	// ============================================================
	// Taps.
	// Unselected taps pulse every other cycle, so a wrong selection shows at once.
	logic tickPhase_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			tickPhase_ff <= 1'b0;
		else
			tickPhase_ff <= ~tickPhase_ff;
	end

	always_comb begin
		prescTick = tickPhase_ff ? 7'h7F : 7'h00;
		if (tapSel != 3'h7)
			prescTick[tapSel] = fire;
	end
endmodule

// File: verification/eight_bit_reload_timer_test.sv
`timescale 1ns/1ps
`include "ebrt_map.svh"

module eight_bit_reload_timer_test;
	logic        clock, rst, awvalid, wvalid, bready, arvalid, rready, fire, eventInputPin;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, bResp;
	logic        awready, wready, bvalid, arready, rvalid, cpuIrq;
	logic [6:0]  prescTick;
	logic [2:0]  tapSel, s;
	int          nMismatch, nChecks;

	ebrt_timer i_ebrt_timer (.clock(clock), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .prescTick(prescTick), .eventInputPin(eventInputPin), .cpuIrq(cpuIrq));

	ebrt_tap_model i_ebrt_tap_model (.clock(clock), .rst(rst), .tapSel(tapSel), .fire(fire),
		.prescTick(prescTick));

	always #50 clock = ~clock;

	// ============================================================
	// Bus and check tasks.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nChecks++;
		if (seen !== exp) begin
			nMismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge clock);
			if (aw && awready === 1'b1) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		bResp = bresp;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r, input string nm);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		chk(nm, rdata, {24'h0, d});
		chk({nm, " resp"}, {30'h0, rresp}, {30'h0, r});
	endtask

	// Pulses are spaced two cycles apart; the wait lets the last count land.
	task automatic tick(input int n);
		repeat (n) begin
			fire <= 1'b1;
			@(posedge clock);
			fire <= 1'b0;
			@(posedge clock);
		end
		repeat (3) @(posedge clock);
	endtask

	task automatic pin(input logic v);
		eventInputPin <= v;
		repeat (4) @(posedge clock);
	endtask

	task automatic wrapUp();
		$display("Comparisons %0d, mismatches %0d", nChecks, nMismatch);
		if (nMismatch == 0 && nChecks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ============================================================
	// Tests.
	initial begin
		{clock, awvalid, wvalid, bready, arvalid, rready, fire, eventInputPin} = '0;
		{awaddr, araddr, wdata, tapSel} = '0;
		wstrb = 4'hF;
		rst = 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rc(`EBRT_OFF_MODE, 8'h78, `EBRT_RESP_OKAY, "mode");
		rc(`EBRT_OFF_COUNT, 8'h00, `EBRT_RESP_OKAY, "count");
		rc(8'h20, 8'h00, `EBRT_RESP_SLVERR, "unmapped");
		wr(8'h20, 8'h55);
		chk("bresp", {30'h0, bResp}, {30'h0, `EBRT_RESP_SLVERR});
		// Odd codes run auto-reload, codes 2,3,6 enable the interrupt.
		for (int i = 0; i < 7; i++) begin
			s = i[2:0];
			wr(`EBRT_OFF_MODE, {s[0], {4{s[2]}}, s});
			chk("bresp", {30'h0, bResp}, {30'h0, `EBRT_RESP_OKAY});
			tapSel <= s;
			rc(`EBRT_OFF_MODE, {s[0], 4'hF, s}, `EBRT_RESP_OKAY, "mode");
			wr(`EBRT_OFF_IRQ_EN, {7'h0, s[1]});
			wr(`EBRT_OFF_COUNT, 8'hFD);
			rc(`EBRT_OFF_COUNT, 8'hFD, `EBRT_RESP_OKAY, "count");
			wr(`EBRT_OFF_IRQ_REQ, 8'h01);
			tick(2);
			rc(`EBRT_OFF_COUNT, 8'hFF, `EBRT_RESP_OKAY, "count");
			rc(`EBRT_OFF_IRQ_REQ, 8'h00, `EBRT_RESP_OKAY, "flag");
			tick(1);
			rc(`EBRT_OFF_COUNT, s[0] ? 8'hFD : 8'h00, `EBRT_RESP_OKAY, "count");
			rc(`EBRT_OFF_IRQ_REQ, 8'h01, `EBRT_RESP_OKAY, "flag");
			chk("cpuIrq", {31'h0, cpuIrq}, {31'h0, s[1]});
			wr(`EBRT_OFF_IRQ_REQ, 8'h01);
			chk("cpuIrq", {31'h0, cpuIrq}, 32'h0);
		end
		tapSel <= 3'h7;
		wr(`EBRT_OFF_MODE, 8'h07);
		rc(`EBRT_OFF_MODE, 8'h7F, `EBRT_RESP_OKAY, "mode");
		wr(`EBRT_OFF_EDGE, 8'h01);
		wr(`EBRT_OFF_COUNT, 8'h10);
		pin(1'b1);
		rc(`EBRT_OFF_COUNT, 8'h11, `EBRT_RESP_OKAY, "rise");
		pin(1'b0);
		rc(`EBRT_OFF_COUNT, 8'h11, `EBRT_RESP_OKAY, "fall");
		wr(`EBRT_OFF_EDGE, 8'h00);
		pin(1'b1);
		rc(`EBRT_OFF_COUNT, 8'h11, `EBRT_RESP_OKAY, "rise");
		pin(1'b0);
		rc(`EBRT_OFF_COUNT, 8'h12, `EBRT_RESP_OKAY, "fall");
		tapSel <= 3'h0;
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rc(`EBRT_OFF_MODE, 8'h78, `EBRT_RESP_OKAY, "mode");
		rc(`EBRT_OFF_COUNT, 8'h00, `EBRT_RESP_OKAY, "count");
		wrapUp();
	end

	initial begin
		repeat (20000) @(posedge clock);
		nMismatch++;
		wrapUp();
	end
endmodule
